//--- rtl/clknet_cfg.svh
// Constants for the clock network and PLL dynamic control pair.
// Assumes one 200 MHz clock, synchronous active-high reset.
`ifndef CLKNET_CFG_SVH
`define CLKNET_CFG_SVH
`define N_CLK_IN        8
`define N_PRIMARY       8
`define N_SECONDARY     8
`define N_EDGE          4
`define N_SEL_SRC       27
`define N_ROUTING       11
`define N_PLL_OUT       4
`define SRC_IO_BASE     0
`define SRC_ROUTE_BASE  8
`define SRC_DIV_BASE    19
`define SRC_PLL_BASE    27
`define PHASE_W         8
`define PHASE_RST       8'h00
`define DIV_RST         8'h01
`define T_LOCK_NS       1000
`define CLK_PERIOD_NS   5
`define LOCK_CYC        ((`T_LOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REG_PHASE0      8'h00
`define REG_DIV         8'h04
`define REG_REFSEL      8'h05
`define REG_STATUS      8'h06
`endif

//--- rtl/clknet_ctrl.sv
// Fabric controller for PLL phase stepping and WISHBONE rewrites.
// Assumes device end on same clk; the device end stands for the hard block.
`timescale 1ns/1ps
`include "clknet_cfg.svh"
module clknet_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  pll_ctl_if.ctrl          link,
  input  wire logic        step_req,
  input  wire logic [1:0]  step_sel,
  input  wire logic        step_dir,
  input  wire logic        ref_choice,
  input  wire logic        wr_req,
  input  wire logic        wr_we,
  input  wire logic [7:0]  wr_adr,
  input  wire logic [7:0]  wr_dat,
  output logic             busy,
  output logic             rd_valid,
  output logic [7:0]       rd_dat,
  output logic             locked
);
  logic [1:0] sel_q;
  logic       dir_q;
  logic       tog_q;
  logic       ref_q;
  logic       cyc_q;
  logic       we_q;
  logic [7:0] adr_q;
  logic [7:0] dat_q;
  logic       start;

  assign start = wr_req && !cyc_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= 2'd0;
      dir_q <= 1'b0;
      tog_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_choice;
      if (step_req) begin
        sel_q <= step_sel;
        dir_q <= step_dir;
        tog_q <= ~tog_q;
      end
    end
  end

  // Stands in for the embedded function hard block bus access
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_q    <= 1'b0;
      we_q     <= 1'b0;
      adr_q    <= 8'h00;
      dat_q    <= 8'h00;
      rd_valid <= 1'b0;
      rd_dat   <= 8'h00;
      locked   <= 1'b0;
    end else begin
      locked   <= link.pll_lock;
      rd_valid <= cyc_q && link.wb_ack && !we_q;
      if (cyc_q && link.wb_ack) begin
        cyc_q  <= 1'b0;
        rd_dat <= link.wb_dat_r;
      end else if (start) begin
        cyc_q <= 1'b1;
        we_q  <= wr_we;
        adr_q <= wr_adr;
        dat_q <= wr_dat;
      end
    end
  end

  assign busy                      = cyc_q;
  assign link.phase_output_select  = sel_q;
  assign link.phase_step_direction = dir_q;
  assign link.phase_step_toggle    = tog_q;
  assign link.ref_sel              = ref_q;
  assign link.wb_cyc               = cyc_q;
  assign link.wb_stb               = cyc_q;
  assign link.wb_we                = we_q;
  assign link.wb_adr               = adr_q;
  assign link.wb_dat_w             = dat_q;
endmodule

//--- rtl/clknet_dev.sv
// Clock network selectors and PLL dynamic control, device end.
// Assumes controller on same clk; clock pins sampled as plain levels.
`timescale 1ns/1ps
`include "clknet_cfg.svh"
module clknet_dev (
  input  wire logic                     clk,
  input  wire logic                     rst,
  pll_ctl_if.dev                        link,
  input  wire logic [`N_CLK_IN-1:0]     true_clock_pin,
  input  wire logic [`N_CLK_IN-1:0]     comp_clock_pin,
  input  wire logic [`N_CLK_IN-1:0]     diff_mode,
  input  wire logic [`N_CLK_IN-1:0]     clk_in_used,
  input  wire logic [`N_ROUTING-1:0]    routing_in,
  input  wire logic [`N_PRIMARY-1:0]    div_in,
  input  wire logic [`N_SECONDARY-1:0]  fabric_ctl_in,
  input  wire logic [`N_EDGE-1:0]       fabric_interface_source,
  input  wire logic [`N_EDGE-1:0]       edge_bridge_in,
  input  wire logic [5*`N_PRIMARY-1:0]  primary_sel,
  input  wire logic [2*`N_EDGE-1:0]     edge_sel,
  input  wire logic                     dyn_phase_en,
  input  wire logic [`PHASE_W-1:0]      static_phase,
  input  wire logic                     ref_clk_a,
  input  wire logic                     ref_clk_b,
  input  wire logic                     pll_feedback_in,
  output logic      [`N_CLK_IN-1:0]     gpio_in,
  output logic      [`N_PRIMARY-1:0]    primary_clk,
  output logic      [`N_SECONDARY-1:0]  secondary_net,
  output logic      [`N_EDGE-1:0]       edge_clk,
  output logic      [`N_PLL_OUT-1:0]    pll_out,
  output logic      [4*`PHASE_W-1:0]    phase_out,
  output logic      [`PHASE_W-1:0]      div_out
);
  logic [`N_CLK_IN-1:0]     tp_s1_q, tp_s2_q, cp_s1_q, cp_s2_q;
  logic [`N_ROUTING-1:0]    rt_s1_q, rt_s2_q;
  logic [`N_PRIMARY-1:0]    dv_s1_q, dv_s2_q;
  logic [1:0]               rf_s1_q, rf_s2_q;
  logic                     fb_s1_q, fb_s2_q;
  logic [`PHASE_W-1:0]      phase_q [`N_PLL_OUT];
  logic [`PHASE_W-1:0]      div_q;
  logic                     refsel_q;
  logic                     tog_q;
  logic [15:0]              lock_cnt_q;
  logic                     lock_q;
  logic                     ack_q;
  logic [7:0]               rdat_q;
  clknet_pkg::wb_state_t    wb_st_q;
  logic [`N_CLK_IN-1:0]     io_src;
  logic [`N_SEL_SRC+`N_PLL_OUT-1:0] src_vec;
  logic                     ref_clk;
  logic                     step_ev;
  logic                     fb_step;
  logic                     wb_req;
  logic                     wb_wr;
  logic                     relock;
  logic                     mismatch;
  logic [7:0]               rd_mux;

  always_ff @(posedge clk) begin
    tp_s1_q <= true_clock_pin;
    tp_s2_q <= tp_s1_q;
    cp_s1_q <= comp_clock_pin;
    cp_s2_q <= cp_s1_q;
    rt_s1_q <= routing_in;
    rt_s2_q <= rt_s1_q;
    dv_s1_q <= div_in;
    dv_s2_q <= dv_s1_q;
    rf_s1_q <= {ref_clk_b, ref_clk_a};
    rf_s2_q <= rf_s1_q;
    fb_s1_q <= pll_feedback_in;
    fb_s2_q <= fb_s1_q;
  end

  // Single-ended uses true pin only; differential needs both legs
  assign io_src  = tp_s2_q & ~(diff_mode & cp_s2_q);
  assign src_vec = {pll_out, dv_s2_q, rt_s2_q, io_src};
  assign ref_clk = refsel_q ? rf_s2_q[1] : rf_s2_q[0];

  assign step_ev  = dyn_phase_en && (link.phase_step_toggle != tog_q);
  assign fb_step  = step_ev && (link.phase_output_select == 2'd0);
  assign wb_req   = link.wb_cyc && link.wb_stb && (wb_st_q == clknet_pkg::WB_IDLE);
  assign wb_wr    = wb_req && link.wb_we;
  assign relock   = fb_step || (wb_wr && link.wb_adr <= `REG_REFSEL);
  assign mismatch = ref_clk != fb_s2_q;

  assign rd_mux = (link.wb_adr < 8'h04) ? phase_q[link.wb_adr[1:0]] :
                  (link.wb_adr == `REG_DIV) ? div_q :
                  (link.wb_adr == `REG_REFSEL) ? {7'h00, refsel_q} :
                  (link.wb_adr == `REG_STATUS) ? {7'h00, lock_q} : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= link.phase_step_toggle;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `N_PLL_OUT; g++) begin : g_ph
      always_ff @(posedge clk) begin
        if (rst) begin
          phase_q[g] <= `PHASE_RST;
        end else if (!dyn_phase_en) begin
          phase_q[g] <= static_phase;
        end else if (step_ev && link.phase_output_select == g) begin
          phase_q[g] <= link.phase_step_direction ? phase_q[g] + 8'h01 :
                                                    phase_q[g] - 8'h01;
        end else if (wb_wr && link.wb_adr == g) begin
          phase_q[g] <= link.wb_dat_w;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          pll_out[g] <= 1'b0;
        end else begin
          pll_out[g] <= lock_q & ref_clk;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          edge_clk[g] <= 1'b0;
        end else begin
          case (edge_sel[2*g +: 2])
            2'd0:    edge_clk[g] <= pll_out[g];
            2'd1:    edge_clk[g] <= io_src[g];
            2'd2:    edge_clk[g] <= edge_bridge_in[g];
            default: edge_clk[g] <= fabric_interface_source[g];
          endcase
        end
      end
      assign phase_out[g*`PHASE_W +: `PHASE_W] = phase_q[g];
    end
    for (g = 0; g < `N_PRIMARY; g++) begin : g_pri
      always_ff @(posedge clk) begin
        if (rst) begin
          primary_clk[g] <= 1'b0;
        end else begin
          primary_clk[g] <= src_vec[primary_sel[5*g +: 5]];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      secondary_net <= '0;
      gpio_in       <= '0;
    end else begin
      secondary_net <= fabric_ctl_in;
      gpio_in       <= tp_s2_q & ~clk_in_used;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q    <= `DIV_RST;
      refsel_q <= 1'b0;
    end else begin
      if (wb_wr && link.wb_adr == `REG_DIV) begin
        div_q <= link.wb_dat_w;
      end
      if (wb_wr && link.wb_adr == `REG_REFSEL) begin
        refsel_q <= link.wb_dat_w[0];
      end else begin
        refsel_q <= link.ref_sel;
      end
    end
  end
  assign div_out = div_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_st_q <= clknet_pkg::WB_IDLE;
      ack_q   <= 1'b0;
      rdat_q  <= 8'h00;
    end else begin
      case (wb_st_q)
        clknet_pkg::WB_IDLE: begin
          ack_q <= wb_req;
          if (wb_req) begin
            rdat_q  <= rd_mux;
            wb_st_q <= clknet_pkg::WB_ACK;
          end
        end
        default: begin
          ack_q   <= 1'b0;
          wb_st_q <= clknet_pkg::WB_IDLE;
        end
      endcase
    end
  end
  assign link.wb_ack   = ack_q;
  assign link.wb_dat_r = rdat_q;

  // Lock held low for the full lock time after a ref/feedback mismatch, a setting write or an output 0 step
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_cnt_q <= 16'h0000;
      lock_q     <= 1'b0;
    end else if (relock || mismatch) begin
      lock_cnt_q <= 16'h0000;
      lock_q     <= 1'b0;
    end else if (lock_cnt_q < 16'(`LOCK_CYC)) begin
      lock_cnt_q <= lock_cnt_q + 16'h0001;
      lock_q     <= 1'b0;
    end else begin
      lock_q <= 1'b1;
    end
  end
  assign link.pll_lock = lock_q;
endmodule

//--- rtl/clknet_pkg.sv
// Types for the clock network and PLL dynamic control pair.
// Assumes clknet_cfg.svh holds all figures.
package clknet_pkg;
  typedef enum logic [1:0] {WB_IDLE, WB_ACK} wb_state_t;
  typedef logic [4:0] src_sel_t;
  typedef logic [1:0] edge_sel_t;
endpackage

//--- rtl/pll_ctl_if.sv
// Link between the clock network device and its fabric controller.
// Assumes both ends share clk and rst.
`timescale 1ns/1ps
`include "clknet_cfg.svh"
interface pll_ctl_if;
  logic [1:0] phase_output_select;
  logic       phase_step_direction;
  logic       phase_step_toggle;
  logic       ref_sel;
  logic       wb_cyc;
  logic       wb_stb;
  logic       wb_we;
  logic [7:0] wb_adr;
  logic [7:0] wb_dat_w;
  logic [7:0] wb_dat_r;
  logic       wb_ack;
  logic       pll_lock;
  modport dev  (input phase_output_select, phase_step_direction, phase_step_toggle,
                ref_sel, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w,
                output wb_dat_r, wb_ack, pll_lock);
  modport ctrl (output phase_output_select, phase_step_direction, phase_step_toggle,
                ref_sel, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w,
                input wb_dat_r, wb_ack, pll_lock);
endinterface

//--- testbench/clknet_link_sva.sv
// Checker on the link between device end and fabric controller.
// Assumes the bench holds reference and feedback levels equal.
`timescale 1ns/1ps
`include "clknet_cfg.svh"
module clknet_link_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       phase_step_toggle,
  input wire logic [1:0] phase_output_select,
  input wire logic       wb_cyc,
  input wire logic       wb_stb,
  input wire logic       wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [7:0] wb_dat_r,
  input wire logic       wb_ack,
  input wire logic       pll_lock
);
  localparam int LockCyc = `LOCK_CYC;
  logic [9:0] quiet_q;
  logic       tog_q;
  wire        take = wb_cyc && wb_stb && !wb_ack;
  wire        upd  = take && wb_we && wb_adr <= `REG_REFSEL;
  // Cycles since the last event that may cost lock
  always_ff @(posedge clk) begin
    tog_q <= phase_step_toggle;
    if (rst || upd || (tog_q != phase_step_toggle && phase_output_select == 2'h0)) quiet_q <= '0;
    else if (quiet_q != 10'h3ff) quiet_q <= quiet_q + 10'h001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wb_take_s;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence wb_answer_s;
    wb_ack ##1 !wb_ack;
  endsequence
  ack_follows_req_a: assert property (wb_take_s |=> wb_answer_s)
    else $error("ack missing after request");
  ack_has_req_a: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
    else $error("ack without request");
  write_drops_lock_a: assert property (upd |-> ##[1:2] !pll_lock)
    else $error("lock kept after setting write");
  status_keeps_lock_a: assert property (
    take && wb_we && wb_adr == `REG_STATUS && pll_lock |=> pll_lock[*3])
    else $error("status write cost lock");
  relock_wait_a: assert property ($rose(pll_lock) |-> quiet_q >= LockCyc - 1)
    else $error("lock regained too early");
  relock_bound_a: assert property (quiet_q == 10'(LockCyc + 6) |-> pll_lock)
    else $error("lock not regained");
  unmapped_zero_a: assert property (
    wb_ack && !wb_we && wb_adr > `REG_STATUS |-> wb_dat_r == 8'h00)
    else $error("unmapped read not zero");
  dat_r_holds_a: assert property (!(wb_cyc && wb_stb) |=> $stable(wb_dat_r))
    else $error("read data moved while idle");
endmodule

//--- testbench/clock_network_pll_dynamic_control_bench.sv
// Bench joining device end and controller through the link.
// Assumes both ends on one 200 MHz clock, sync active-high reset.
`timescale 1ns/1ps
`include "clknet_cfg.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module clock_network_pll_dynamic_control_bench;
  logic clk, rst, step_req, step_dir, ref_choice, wr_req, wr_we, dyn_phase_en;
  logic busy, rd_valid, locked, rb, fb;
  logic [1:0] step_sel;
  logic [7:0] wr_adr, wr_dat, rd_dat, q, tp, cp, used, gpio_in, prim, sec, fab_ctl, st_ph, div_out;
  logic [3:0] edge_clk, pll_out, bridge, fis;
  logic [10:0] route;
  logic [39:0] psel;
  logic [7:0] esel, dm;
  logic [31:0] phase_out;
  int n_fail, tests_run, cyc_cnt, k;
  int sel_t[5] = '{0, 1, 8, 18, 26};
  logic [7:0] exp_t[5] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
  pll_ctl_if link ();
  clknet_dev i_clknet_dev (.clk(clk), .rst(rst), .link(link), .true_clock_pin(tp),
    .comp_clock_pin(cp), .diff_mode(dm), .clk_in_used(used), .routing_in(route),
    .div_in(8'h80), .fabric_ctl_in(fab_ctl), .fabric_interface_source(fis),
    .edge_bridge_in(bridge), .primary_sel(psel), .edge_sel(esel), .dyn_phase_en(dyn_phase_en),
    .static_phase(st_ph), .ref_clk_a(1'b0), .ref_clk_b(rb), .pll_feedback_in(fb),
    .gpio_in(gpio_in), .primary_clk(prim), .secondary_net(sec), .edge_clk(edge_clk),
    .pll_out(pll_out), .phase_out(phase_out), .div_out(div_out));
  clknet_ctrl i_clknet_ctrl (.clk(clk), .rst(rst), .link(link), .step_req(step_req),
    .step_sel(step_sel), .step_dir(step_dir), .ref_choice(ref_choice), .wr_req(wr_req),
    .wr_we(wr_we), .wr_adr(wr_adr), .wr_dat(wr_dat), .busy(busy), .rd_valid(rd_valid),
    .rd_dat(rd_dat), .locked(locked));
  clknet_link_sva i_clknet_link_sva (.clk(clk), .rst(rst),
    .phase_output_select(link.phase_output_select),
    .phase_step_toggle(link.phase_step_toggle), .wb_cyc(link.wb_cyc), .wb_stb(link.wb_stb),
    .wb_we(link.wb_we), .wb_adr(link.wb_adr), .wb_dat_r(link.wb_dat_r),
    .wb_ack(link.wb_ack), .pll_lock(link.pll_lock));
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    wr_we <= we;
    wr_adr <= adr;
    wr_dat <= dat;
    wr_req <= 1'b1;
    @(posedge clk) wr_req <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) #1;
      if (rd_valid === 1'b1) q = rd_dat;
      if (busy === 1'b0 && i > 0) break;
    end
  endtask
  task automatic step(input logic [1:0] s, input logic d);
    step_sel <= s;
    step_dir <= d;
    step_req <= 1'b1;
    @(posedge clk) step_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wait_lock;
    for (k = 0; k < `LOCK_CYC + 20 && locked !== 1'b1; k++) @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      n_fail++;
      wrap_up;
    end
  end
  initial begin
    {rst, step_req, step_dir, ref_choice, wr_req, wr_we, step_sel} = 8'h80;
    {wr_adr, wr_dat, q, st_ph, fab_ctl, psel, esel, dm, rb, fb} = '0;
    {tp, cp, used, route, bridge, fis, dyn_phase_en} = {8'ha5, 8'h05, 8'h0f, 11'h400, 9'h0d3};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    `CHK(locked, 1'b0)
    `CHK(div_out, 8'h01)
    wait_lock;
    `CHK(locked, 1'b1)
    `CHK(gpio_in, 8'ha0)
    for (int i = 0; i < 5; i++) begin
      psel <= {8{5'(sel_t[i])}};
      repeat (5) @(posedge clk);
      #1;
      `CHK(prim, exp_t[i])
    end
    dm <= 8'h01;
    psel <= '0;
    repeat (5) @(posedge clk) #1;
    `CHK(prim, 8'h00)
    psel <= {8{5'h02}};
    repeat (5) @(posedge clk) #1;
    `CHK(prim, 8'hff)
    dm <= 8'h00;
    esel <= 8'haa;
    fab_ctl <= 8'h3c;
    repeat (3) @(posedge clk) #1;
    `CHK(edge_clk, 4'h6)
    `CHK(sec, 8'h3c)
    esel <= 8'hff;
    repeat (3) @(posedge clk) #1;
    `CHK(edge_clk, 4'h9)
    esel <= 8'h55;
    repeat (3) @(posedge clk) #1;
    `CHK(edge_clk, 4'h5)
    wb(1'b0, `REG_STATUS, 8'h00);
    `CHK(q, 8'h01)
    wb(1'b1, `REG_STATUS, 8'h00);
    wb(1'b1, 8'h20, 8'h55);
    `CHK(locked, 1'b1)
    wb(1'b0, 8'h20, 8'h00);
    `CHK(q, 8'h00)
    wb(1'b1, 8'h01, 8'h5a);
    `CHK(phase_out[15:8], 8'h5a)
    `CHK(locked, 1'b0)
    wb(1'b1, `REG_DIV, 8'h07);
    `CHK(div_out, 8'h07)
    `CHK(locked, 1'b0)
    wb(1'b0, `REG_DIV, 8'h00);
    `CHK(q, 8'h07)
    wait_lock;
    step(2'd0, 1'b1);
    `CHK(phase_out[7:0], 8'h01)
    `CHK(locked, 1'b0)
    step(2'd2, 1'b0);
    `CHK(phase_out[23:16], 8'hff)
    wait_lock;
    dyn_phase_en <= 1'b0;
    st_ph <= 8'h33;
    repeat (3) @(posedge clk) #1;
    `CHK(phase_out, {4{8'h33}})
    ref_choice <= 1'b1;
    rb <= 1'b1;
    fb <= 1'b1;
    esel <= 8'h00;
    repeat (4) @(posedge clk) #1;
    `CHK(pll_out, 4'hf)
    `CHK(edge_clk, 4'hf)
    `CHK(locked, 1'b1)
    wrap_up;
  end
endmodule
